// ===== core/foa_defines.vh
// register offsets, field positions, reset values and mode codes for frame offset alignment
`ifndef FOA_DEFINES_VH
`define FOA_DEFINES_VH
`define FOA_ADDR_W 8
`define FOA_DATA_W 16
`define FOA_ADDR_OUT_OFS0 8'h0a
`define FOA_ADDR_OUT_OFS1 8'h0b
`define FOA_ADDR_OUT_OFS2 8'h0c
`define FOA_ADDR_OUT_OFS3 8'h0d
`define FOA_ADDR_IN_SHIFT0 8'h20
`define FOA_IN_SHIFT_REGS 8
`define FOA_ADDR_MODE 8'h30
`define FOA_ADDR_MEAS 8'h31
`define FOA_OUT_OFS_RESET 16'h0000
`define FOA_IN_SHIFT_RESET 16'h0000
`define FOA_MODE_RESET 3'h0
`define FOA_MEAS_FLAG_BIT 9
`define FOA_MEAS_CNT_LSB 0
`define FOA_MEAS_FLAG_RESET 1'b1
`define FOA_MEAS_CNT_RESET 3'h0
`define FOA_CODE_MAX 4'h9
`define FOA_MODE_2M 3'h0
`define FOA_MODE_4M 3'h1
`define FOA_MODE_8M 3'h2
`define FOA_MODE_16M 3'h3
`define FOA_MODE_2M_4M 3'h4
`define FOA_MODE_4M_8M 3'h5
`define FOA_MODE_16M_8M 3'h6
`define FOA_ADV_STEP_PS 15000
`define FOA_CLK_PERIOD_PS 50000
`endif

// ===== core/foa_core.v
// per-stream input capture delay and output advance selection with its register file
`timescale 1ns/1ps
`include "foa_defines.vh"

// Function
// - code picks quarter-period capture delay, 0..9
// - measurement gives half-step count and flag
// - no shift: flag 1, count 000, code 0
// - four registers, eight two-bit fields each
// - output offset registers reset zero, read/write
// - field sets early drive of bit 0
// - 00/01/10/11 give 0/15/30/45 ns advance
// - advance only in 8/16/4&8/16&8 modes
// - code sets wait before storing bit 0
module foa_core #(
	parameter STREAMS = 32
) (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// register port
	input wire [`FOA_ADDR_W-1:0] reg_addr,
	input wire [`FOA_DATA_W-1:0] reg_wr_data,
	input wire reg_wr_en,
	input wire reg_rd_en,
	output reg [`FOA_DATA_W-1:0] reg_rd_data_r,
	// frame delay measurement from the measuring unit
	input wire meas_valid,
	input wire [3:0] meas_quarter_steps,
	// external frame pulse, active low pin
	input wire frame_pulse_in_n,
	// per-stream input capture timing
	output reg [STREAMS-1:0] bit0_capture_r,
	output reg [2*STREAMS-1:0] capture_phase_r,
	// per-stream output advance tap, units of 15 ns
	output reg [2*STREAMS-1:0] output_advance_r,
	output reg frame_start_r
);

	localparam NREG_OUT = 4;

	// clamp undefined codes to the largest shift
	function [3:0] clamp_code;
		input [3:0] code;
		begin
			clamp_code = (code > `FOA_CODE_MAX) ? `FOA_CODE_MAX : code;
		end
	endfunction

	// true for the modes in which output advance is honoured
	function adv_allowed;
		input [2:0] mode;
		begin
			case (mode)
				`FOA_MODE_8M: adv_allowed = 1'b1;
				`FOA_MODE_16M: adv_allowed = 1'b1;
				`FOA_MODE_4M_8M: adv_allowed = 1'b1;
				`FOA_MODE_16M_8M: adv_allowed = 1'b1;
				default: adv_allowed = 1'b0;
			endcase
		end
	endfunction

	reg [`FOA_DATA_W-1:0] out_offset_streams_0_7_r;
	reg [`FOA_DATA_W-1:0] out_offset_streams_8_15_r;
	reg [`FOA_DATA_W-1:0] out_offset_streams_16_23_r;
	reg [`FOA_DATA_W-1:0] out_offset_streams_24_31_r;
	reg [`FOA_DATA_W-1:0] in_shift_r [0:`FOA_IN_SHIFT_REGS-1];
	reg [2:0] mode_r;
	reg half_step_flag_r;
	reg [2:0] half_step_count_r;
	reg [`FOA_DATA_W-1:0] rd_nxt;
	reg fp_meta_r;
	reg fp_sync_r;
	reg fp_prev_r;
	reg [2:0] fp_hist_r;
	wire fp_fall;
	wire [2*STREAMS-1:0] out_fields;
	wire [3:0] meas_clamped;
	integer i;

	assign out_fields = {out_offset_streams_24_31_r, out_offset_streams_16_23_r,
		out_offset_streams_8_15_r, out_offset_streams_0_7_r};
	assign meas_clamped = clamp_code(meas_quarter_steps);

	// register writes
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_offset_streams_0_7_r <= `FOA_OUT_OFS_RESET;
			out_offset_streams_8_15_r <= `FOA_OUT_OFS_RESET;
			out_offset_streams_16_23_r <= `FOA_OUT_OFS_RESET;
			out_offset_streams_24_31_r <= `FOA_OUT_OFS_RESET;
			for (i = 0; i < `FOA_IN_SHIFT_REGS; i = i + 1) begin
				in_shift_r[i] <= `FOA_IN_SHIFT_RESET;
			end
			mode_r <= `FOA_MODE_RESET;
		end else if (reg_wr_en) begin
			case (reg_addr)
				`FOA_ADDR_OUT_OFS0: out_offset_streams_0_7_r <= reg_wr_data;
				`FOA_ADDR_OUT_OFS1: out_offset_streams_8_15_r <= reg_wr_data;
				`FOA_ADDR_OUT_OFS2: out_offset_streams_16_23_r <= reg_wr_data;
				`FOA_ADDR_OUT_OFS3: out_offset_streams_24_31_r <= reg_wr_data;
				`FOA_ADDR_MODE: mode_r <= reg_wr_data[2:0];
				default: begin
					if (reg_addr >= `FOA_ADDR_IN_SHIFT0 &&
						reg_addr < `FOA_ADDR_IN_SHIFT0 + `FOA_IN_SHIFT_REGS) begin
						in_shift_r[reg_addr[2:0]] <= reg_wr_data;
					end
				end
			endcase
		end
	end

	// measurement result: half steps and whole-half flag
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_step_flag_r <= `FOA_MEAS_FLAG_RESET;
			half_step_count_r <= `FOA_MEAS_CNT_RESET;
		end else if (meas_valid) begin
			half_step_count_r <= meas_clamped[3:1];
			half_step_flag_r <= ~meas_clamped[0];
		end
	end

	// read mux; data stands only in the cycle after the strobe
	always @* begin
		rd_nxt = {`FOA_DATA_W{1'b0}};
		case (reg_addr)
			`FOA_ADDR_OUT_OFS0: rd_nxt = out_offset_streams_0_7_r;
			`FOA_ADDR_OUT_OFS1: rd_nxt = out_offset_streams_8_15_r;
			`FOA_ADDR_OUT_OFS2: rd_nxt = out_offset_streams_16_23_r;
			`FOA_ADDR_OUT_OFS3: rd_nxt = out_offset_streams_24_31_r;
			`FOA_ADDR_MODE: rd_nxt[2:0] = mode_r;
			`FOA_ADDR_MEAS: begin
				rd_nxt[`FOA_MEAS_FLAG_BIT] = half_step_flag_r;
				rd_nxt[`FOA_MEAS_CNT_LSB+2:`FOA_MEAS_CNT_LSB] = half_step_count_r;
			end
			default: begin
				if (reg_addr >= `FOA_ADDR_IN_SHIFT0 &&
					reg_addr < `FOA_ADDR_IN_SHIFT0 + `FOA_IN_SHIFT_REGS) begin
					rd_nxt = in_shift_r[reg_addr[2:0]];
				end
			end
		endcase
	end

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_data_r <= {`FOA_DATA_W{1'b0}};
		end else begin
			reg_rd_data_r <= reg_rd_en ? rd_nxt : {`FOA_DATA_W{1'b0}};
		end
	end

	// frame pulse pin is asynchronous: two flops, then edge detect
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fp_meta_r <= 1'b1;
			fp_sync_r <= 1'b1;
			fp_prev_r <= 1'b1;
			fp_hist_r <= 3'h0;
			frame_start_r <= 1'b0;
		end else begin
			fp_meta_r <= frame_pulse_in_n;
			fp_sync_r <= fp_meta_r;
			fp_prev_r <= fp_sync_r;
			fp_hist_r <= {fp_hist_r[1:0], fp_fall};
			frame_start_r <= fp_fall;
		end
	end

	assign fp_fall = fp_prev_r & ~fp_sync_r;

	// per stream: whole periods delay the strobe, quarter remainder goes to the capture phase
	genvar n;
	generate
		for (n = 0; n < STREAMS; n = n + 1) begin : g_stream
			wire [3:0] code;
			wire [1:0] whole;
			wire [1:0] field;
			assign code = clamp_code(in_shift_r[n/4][4*(n%4)+3:4*(n%4)]);
			assign whole = code[3:2];
			assign field = out_fields[2*n+1:2*n];
			always @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					bit0_capture_r[n] <= 1'b0;
					capture_phase_r[2*n+1:2*n] <= 2'h0;
					output_advance_r[2*n+1:2*n] <= 2'h0;
				end else begin
					// whole = 0 strobes with the edge, 1 and 2 follow later
					case (whole)
						2'h0: bit0_capture_r[n] <= fp_fall;
						2'h1: bit0_capture_r[n] <= fp_hist_r[0];
						2'h2: bit0_capture_r[n] <= fp_hist_r[1];
						default: bit0_capture_r[n] <= fp_hist_r[2];
					endcase
					capture_phase_r[2*n+1:2*n] <= code[1:0];
					// advance is sub-cycle, so it leaves as a tap code for the pad delay line
					output_advance_r[2*n+1:2*n] <= adv_allowed(mode_r) ? field : 2'h0;
				end
			end
		end
	endgenerate

endmodule // foa_core

// ===== testbench/foa_core_properties.sv
// port assertions for frame offset alignment
`timescale 1ns/1ps
module foa_chk #(parameter STREAMS = 32) (
	// clock and register port
	input wire sys_clk,
	input wire reset_n,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wr_data,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [15:0] reg_rd_data_r,
	// measurement and frame
	input wire meas_valid,
	input wire [3:0] meas_quarter_steps,
	input wire frame_pulse_in_n,
	input wire frame_start_r,
	input wire [STREAMS-1:0] bit0_capture_r,
	input wire [2*STREAMS-1:0] output_advance_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// clamped copy of the last result; reset value means no shift
	reg [3:0] q_r;
	always @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
			q_r <= 4'h0;
		else if (meas_valid)
			q_r <= (meas_quarter_steps > 4'h9) ? 4'h9 : meas_quarter_steps;
	a_rd_idle_zero: assert property (!$past(reg_rd_en) |-> reg_rd_data_r == 16'h0)
		else $error("read data not idle");
	a_rd_unmapped: assert property (reg_rd_en && reg_addr == 8'h0 |=> reg_rd_data_r == 16'h0)
		else $error("unmapped read");
	a_rd_after_wr: assert property (reg_wr_en && reg_addr == 8'h0b ##2
		reg_rd_en && reg_addr == 8'h0b |=> reg_rd_data_r == $past(reg_wr_data, 3))
		else $error("readback");
	a_meas_read: assert property (reg_rd_en && reg_addr == 8'h31 && !meas_valid |=>
		reg_rd_data_r == {6'h0, ~q_r[0], 6'h0, q_r[3:1]}) else $error("measure read");
	a_adv_follows: assert property (reg_wr_en && reg_addr == 8'h0a |=> ##1
		output_advance_r[15:0] == 16'h0 || output_advance_r[15:0] == $past(reg_wr_data, 2))
		else $error("advance field");
	a_start_after_fall: assert property ($fell(frame_pulse_in_n) |-> ##[2:4] frame_start_r)
		else $error("no frame start");
	a_start_once: assert property (frame_start_r |=> !frame_start_r)
		else $error("long frame start");
	a_bit0_window: assert property (bit0_capture_r != 0 |->
		frame_start_r || $past(frame_start_r) || $past(frame_start_r, 2)) else $error("stray capture");
	a_start_bit0: assert property (frame_start_r |-> ##[0:2] bit0_capture_r[0])
		else $error("late capture");
endmodule // foa_chk
bind foa_core foa_chk #(.STREAMS(STREAMS)) i_chk (.*);

// ===== testbench/foa_partner.sv
// frame pulse source and delay measuring unit
`timescale 1ns/1ps
module foa_partner (
	// clock
	input wire sys_clk,
	// towards the block
	output reg frame_pulse_in_n = 1'b1,
	output reg meas_valid = 1'b0,
	output reg [3:0] meas_quarter_steps = 4'h5
);
	// one-cycle low pulse: the shortest the sync flops must still catch
	task frame;
		@(posedge sys_clk) frame_pulse_in_n <= 1'b0;
		@(posedge sys_clk) frame_pulse_in_n <= 1'b1;
	endtask
	// result valid one cycle; the bus shows junk afterwards
	task measure(input [3:0] q);
		@(posedge sys_clk) begin
			meas_valid <= 1'b1;
			meas_quarter_steps <= q;
		end
		@(posedge sys_clk) begin
			meas_valid <= 1'b0;
			meas_quarter_steps <= ~q;
		end
	endtask
endmodule // foa_partner

// ===== testbench/foa_core_tb.sv
// self-checking bench for frame offset alignment
`timescale 1ns/1ps
module foa_core_tb;
	reg sys_clk = 1'b0, reset_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
	reg [7:0] reg_addr = 8'h0;
	reg [15:0] reg_wr_data = 16'h0, rdv;
	wire [15:0] reg_rd_data_r;
	wire meas_valid, frame_pulse_in_n, frame_start_r;
	wire [3:0] meas_quarter_steps;
	wire [31:0] bit0_capture_r;
	wire [63:0] capture_phase_r, output_advance_r;
	integer num_errors = 0, n_compared = 0, cyc = 0, i, k;
	foa_core i_dut (.*);
	foa_partner i_fp (.*);
	always #25 sys_clk = ~sys_clk;
	task chk(input [127:0] nm, input [63:0] e, input [63:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("ERROR %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		@(posedge sys_clk) begin
			reg_wr_en <= 1'b1;
			reg_addr <= a;
			reg_wr_data <= d;
		end
		@(posedge sys_clk) reg_wr_en <= 1'b0;
	endtask
	task rd(input [7:0] a, input [15:0] e);
		@(posedge sys_clk) begin
			reg_rd_en <= 1'b1;
			reg_addr <= a;
		end
		@(posedge sys_clk) reg_rd_en <= 1'b0;
		#1 rdv = reg_rd_data_r;
		chk("reg_rd_data_r", e, rdv);
	endtask
	// write a shift code, then time stream 0 capture against frame start
	task t_cap(input [3:0] w, input [3:0] c);
		wr(8'h20, {12'h0, w});
		@(posedge sys_clk);
		#1 chk("capture_phase_r", c[1:0], capture_phase_r[1:0]);
		i_fp.frame;
		for (k = 0; k < 9 && frame_start_r !== 1'b1; k = k + 1) @(posedge sys_clk) #1;
		for (k = 0; k < 4 && bit0_capture_r[0] !== 1'b1; k = k + 1) @(posedge sys_clk) #1;
		chk("bit0_capture_r", c / 4, k);
	endtask
	task t_meas(input [3:0] q, input [3:0] c);
		i_fp.measure(q);
		rd(8'h31, {6'h0, ~c[0], 6'h0, c[3:1]});
		t_cap({rdv[2:0], ~rdv[9]}, c);
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			num_errors = num_errors + 1;
			conclude;
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(8'h31, 16'h0200);
		for (i = 0; i < 4; i = i + 1) begin
			rd(8'h0a + i, 16'h0);
			wr(8'h0a + i, 16'h1b1b * (i + 1));
			rd(8'h0a + i, 16'h1b1b * (i + 1));
		end
		wr(8'h31, 16'hffff);
		wr(8'h00, 16'hffff);
		rd(8'h00, 16'h0);
		wr(8'h30, 16'h0002);
		@(posedge sys_clk);
		#1 chk("output_advance_r", 64'h6c6c_5151_3636_1b1b, output_advance_r);
		wr(8'h0a, 16'h00e4);
		for (i = 0; i < 7; i = i + 1) begin
			wr(8'h30, i);
			repeat (2) @(posedge sys_clk);
			#1 chk("output_advance_r", (i == 2 || i == 3 || i > 4) ? 8'he4 : 8'h0, output_advance_r[7:0]);
		end
		for (i = 0; i < 10; i = i + 1) t_meas(i, i);
		t_meas(4'hc, 4'h9);
		t_cap(4'hf, 4'h9);
		wr(8'h30, 16'h0000);
		t_cap(4'h0, 4'h0);
		conclude;
	end
endmodule // foa_core_tb
